// ---- design/clip_core.sv ----
// Functional notes
// - power-on defaults to 8-bit bus width
// - 4-bit mode assembles bytes, upper nibble first
// - code 30 sets 8-bit, one line
// - code 0e turns display and cursor on
// - code 06 increments address, no shift
// - code 07 shifts display left per write
// - data write stores byte, increments or decrements address per entry mode
// - text buffer targeted right after reset
// - code 10 moves cursor left only
// - code 1c shifts window and cursor right
// - code 14 moves cursor right only
// - code 02 restores shift and address zero
// - text buffer holds 80 characters
// - shifting never alters buffer contents
// - pictogram bit selects icon-only mode
// - panel-off blanks text, not icons, keeps content
// - sleep pin forces power-down
`timescale 1ns/100ps
`default_nettype none
module clip_core
  import clip_pkg::*;
(
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  // parallel host bus (asynchronous pins)
  input  wire logic              strobe_in,
  input  wire logic              instruction_or_data_select_in,
  input  wire logic              dir_read_in,
  input  wire logic [7:0]        parallel_data_lines_in,
  input  wire logic              sleep_pin_in,
  // status
  output clip_pkg::clip_mode_t   mode_out,
  output logic [6:0]             cursor_addr_out,
  output logic [6:0]             view_offset_out,
  output logic                   display_active_out,
  output logic                   icon_mode_out,
  output logic                   power_down_out,
  output logic                   nibble_pending_out,
  // text buffer read-out for the row driver
  input  wire logic [6:0]        scan_addr_in,
  output logic [7:0]             scan_char_out
);
  import clip_pkg::*;

  typedef enum logic [2:0] {
    CLIP_IDLE = 3'b001,
    CLIP_EXEC = 3'b010,
    CLIP_HOLD = 3'b100
  } clip_state_t;

  // pin synchronisers
  logic [1:0] strobe_sync;
  logic [1:0] sel_sync;
  logic [1:0] dir_sync;
  logic [1:0] sleep_sync;
  logic [7:0] data_s1;
  logic [7:0] data_s2;
  logic       strobe_prev;

  always_ff @(posedge clk_in)
  begin
    strobe_sync <= {strobe_sync[0], strobe_in};
    sel_sync    <= {sel_sync[0], instruction_or_data_select_in};
    dir_sync    <= {dir_sync[0], dir_read_in};
    sleep_sync  <= {sleep_sync[0], sleep_pin_in};
    data_s1     <= parallel_data_lines_in;
    data_s2     <= data_s1;
  end

  wire logic strobe_fall = strobe_prev & ~strobe_sync[1];

  clip_state_t  state;
  clip_state_t  next_state;
  clip_mode_t   mode;
  clip_access_t acc;
  logic         nib_pending;
  logic [3:0]   nib_hi;
  logic [6:0]   addr;
  logic [6:0]   shift;
  logic         asleep;

  function automatic logic [6:0] wrap_step(input logic [6:0] v, input logic up);
    logic [6:0] r;
    r = v;
    if (up)
      r = (v >= ADDR_LAST) ? ADDR_RESET : 7'(v + 7'h01);
    else
      r = (v == ADDR_RESET) ? ADDR_LAST : 7'(v - 7'h01);
    return r;
  endfunction

  // write accepted on falling strobe, only when writing
  wire logic       wr_edge  = strobe_fall & ~dir_sync[1] & ~asleep;
  wire logic [7:0] full_byte = mode.bus_8bit ? data_s2 : {nib_hi, data_s2[7:4]};
  wire logic       byte_done = wr_edge & (mode.bus_8bit | nib_pending);

  // instruction decode, one-hot priority from top bit
  wire logic [7:0] ib       = acc.data;
  wire logic       is_instr = ~acc.sel_data;
  wire logic       is_func  = is_instr & (ib[7:6] == 2'b00) & ib[FS_BIT];
  wire logic       is_shift = is_instr & (ib[7:5] == 3'b000) & ib[SH_BIT] & ~mode.ext_set;
  wire logic       is_dctl  = is_instr & (ib[7:4] == 4'h0) & ib[DC_BIT] & ~mode.ext_set;
  wire logic       is_entry = is_instr & (ib[7:3] == 5'h00) & ib[EM_BIT] & ~mode.ext_set;
  wire logic       is_home  = is_instr & (ib[7:2] == 6'h00) & ib[RH_BIT] & ~mode.ext_set;
  wire logic       is_icon  = is_instr & (ib[7:4] == 4'h0) & ib[DC_BIT] & mode.ext_set;
  wire logic       is_setad = is_instr & ib[7];
  wire logic       is_write = acc.sel_data;

  wire logic       exec = (state == CLIP_EXEC);

  always_comb
  begin
    next_state = state;
    unique case (state)
      CLIP_IDLE: if (byte_done) next_state = CLIP_EXEC;
      CLIP_EXEC: next_state = CLIP_HOLD;
      CLIP_HOLD: if (!strobe_fall) next_state = CLIP_IDLE;
      default:   next_state = CLIP_IDLE;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      strobe_prev <= 1'b0;
    else
      strobe_prev <= strobe_sync[1];
  end

  // fsm and access capture
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state       <= CLIP_IDLE;
      acc         <= '0;
      nib_pending <= 1'b0;
      nib_hi      <= 4'h0;
    end
    else
    begin
      state <= next_state;
      // function set to 4-bit drops a stray half byte; a fresh nibble wins
      if (exec && is_func && !ib[FS_DL_BIT])
        nib_pending <= 1'b0;
      if (wr_edge && !mode.bus_8bit && !nib_pending)
      begin
        nib_hi      <= data_s2[7:4];
        nib_pending <= 1'b1;
      end
      else if (byte_done)
        nib_pending <= 1'b0;
      if (byte_done && state == CLIP_IDLE)
        acc <= '{sel_data: sel_sync[1], dir_read: 1'b0, data: full_byte};
    end
  end

  // mode register
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      mode <= MODE_RESET;
    else if (exec)
    begin
      if (is_func)
      begin
        mode.bus_8bit <= ib[FS_DL_BIT];
        mode.two_line <= ib[FS_M_BIT];
        mode.ext_set  <= ib[FS_H_BIT];
      end
      if (is_dctl)
      begin
        mode.panel_on  <= ib[DC_D_BIT];
        mode.cursor_on <= ib[DC_C_BIT];
        mode.blink_on  <= ib[DC_B_BIT];
      end
      if (is_entry)
      begin
        mode.addr_inc       <= ib[EM_ID_BIT];
        mode.shift_on_write <= ib[EM_S_BIT];
      end
      if (is_icon)
        mode.pictogram_only <= ib[IM_BIT];
    end
  end

  // address and view offset
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      addr  <= ADDR_RESET;
      shift <= SHIFT_RESET;
    end
    else if (exec)
    begin
      if (is_write)
      begin
        addr <= wrap_step(addr, mode.addr_inc);
        if (mode.shift_on_write)
          shift <= wrap_step(shift, mode.addr_inc);
      end
      else if (is_home)
      begin
        addr  <= ADDR_RESET;
        shift <= SHIFT_RESET;
      end
      else if (is_shift)
      begin
        // window shift: cursor rides along with the text, address unchanged
        if (ib[SH_SC_BIT])
          shift <= wrap_step(shift, ~ib[SH_RL_BIT]);
        else
          addr <= wrap_step(addr, ib[SH_RL_BIT]);
      end
      else if (is_setad)
        addr <= (ib[6:0] > ADDR_LAST) ? ADDR_RESET : ib[6:0];
    end
  end

  // power-down from the sleep pin, any mode
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      asleep <= 1'b0;
    else
      asleep <= sleep_sync[1];
  end

  wire logic tb_we = exec & is_write;

  // map of written positions: after reset every position reads blank
  logic [TB_DEPTH-1:0] filled;
  logic                scan_hit;
  logic [7:0]          ram_char;

  wire logic scan_in_range = (scan_addr_in <= ADDR_LAST);
  wire logic scan_written  = scan_in_range && filled[scan_addr_in];

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      filled <= '0;
    else if (tb_we)
      filled[addr] <= 1'b1;
  end

  // lines up with the registered read of the buffer
  always_ff @(posedge clk_in)
  begin
    scan_hit <= scan_written;
  end

  clip_text_ram u_ram (
    .clk_in      (clk_in),
    .wr_en_in    (tb_we),
    .wr_addr_in  (addr),
    .wr_data_in  (ib),
    .rd_addr_in  (scan_addr_in),
    .rd_data_out (ram_char)
  );

  // registered outputs
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      mode_out           <= MODE_RESET;
      cursor_addr_out    <= ADDR_RESET;
      view_offset_out    <= SHIFT_RESET;
      display_active_out <= 1'b0;
      icon_mode_out      <= 1'b0;
      power_down_out     <= 1'b0;
      nibble_pending_out <= 1'b0;
      scan_char_out      <= CHAR_BLANK;
    end
    else
    begin
      mode_out           <= mode;
      cursor_addr_out    <= addr;
      view_offset_out    <= shift;
      display_active_out <= mode.panel_on & ~mode.pictogram_only & ~asleep;
      icon_mode_out      <= mode.pictogram_only & ~asleep;
      power_down_out     <= asleep;
      nibble_pending_out <= nib_pending;
      scan_char_out      <= scan_hit ? ram_char : CHAR_BLANK;
    end
  end

  // checks
  write_advance_a: assert property (@(posedge clk_in) disable iff (rst_in)
    exec && is_write && mode.addr_inc && addr < ADDR_LAST |=> addr == $past(addr) + 7'h01)
    else $error("data write did not advance address");
  home_origin_a: assert property (@(posedge clk_in) disable iff (rst_in)
    exec && is_home |=> addr == ADDR_RESET && shift == SHIFT_RESET)
    else $error("home did not restore origin");
  cursor_only_a: assert property (@(posedge clk_in) disable iff (rst_in)
    exec && is_shift && !ib[SH_SC_BIT] |=> $stable(shift))
    else $error("cursor move changed view");
  view_shift_a: assert property (@(posedge clk_in) disable iff (rst_in)
    exec && is_shift && ib[SH_SC_BIT] && ib[SH_RL_BIT] |=> shift != $past(shift))
    else $error("display shift missing");
  no_shift_a: assert property (@(posedge clk_in) disable iff (rst_in)
    exec && is_write && !mode.shift_on_write |=> $stable(shift))
    else $error("view moved without shift mode");
  func_set_a: assert property (@(posedge clk_in) disable iff (rst_in)
    exec && is_instr && ib == 8'h30 |=> mode.bus_8bit && !mode.two_line)
    else $error("function set not applied");
  dctl_on_a: assert property (@(posedge clk_in) disable iff (rst_in)
    exec && is_instr && ib == 8'h0e && !mode.ext_set |=> mode.panel_on && mode.cursor_on)
    else $error("display control not applied");
  instr_no_store_a: assert property (@(posedge clk_in) disable iff (rst_in)
    exec && is_instr && !is_home && !is_shift && !is_setad |=> $stable(addr))
    else $error("instruction stored as data");
  sleep_out_a: assert property (@(posedge clk_in) disable iff (rst_in)
    sleep_sync[1] |=> ##1 power_down_out)
    else $error("sleep not reported");
  addr_range_a: assert property (@(posedge clk_in) disable iff (rst_in)
    addr <= ADDR_LAST)
    else $error("address beyond text buffer");
  view_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
    exec && is_shift && ib[SH_SC_BIT] |=> $stable(addr))
    else $error("display shift moved the address");
  panel_off_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !mode.panel_on |=> !display_active_out)
    else $error("display active with panel off");
  sleep_block_a: assert property (@(posedge clk_in) disable iff (rst_in)
    asleep && state == CLIP_IDLE |=> state == CLIP_IDLE)
    else $error("access taken while asleep");
  nibble_order_a: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_edge && !mode.bus_8bit && !nib_pending |=> nib_pending)
    else $error("upper nibble not held");

  write_seen_c: cover property (@(posedge clk_in) exec && is_write);
  nibble_seen_c: cover property (@(posedge clk_in) byte_done && !mode.bus_8bit);
  shift_seen_c: cover property (@(posedge clk_in) exec && is_write && mode.shift_on_write);
  home_seen_c: cover property (@(posedge clk_in) exec && is_home);
  icon_seen_c: cover property (@(posedge clk_in) exec && is_icon);
endmodule
`default_nettype wire

// ---- design/clip_pkg.sv ----
package clip_pkg;
  localparam int          DATA_W        = 8;
  localparam int          TB_DEPTH      = 80;
  localparam int          ADDR_W        = 7;
  localparam logic [6:0]  ADDR_RESET    = 7'h00;
  localparam logic [6:0]  ADDR_LAST     = 7'h4f;
  localparam logic [6:0]  SHIFT_RESET   = 7'h00;
  localparam logic [7:0]  CHAR_BLANK    = 8'h20;
  // instruction decode positions
  localparam int          FS_BIT        = 5;
  localparam int          FS_DL_BIT     = 4;
  localparam int          FS_M_BIT      = 2;
  localparam int          FS_H_BIT      = 0;
  localparam int          SH_BIT        = 4;
  localparam int          SH_SC_BIT     = 3;
  localparam int          SH_RL_BIT     = 2;
  localparam int          DC_BIT        = 3;
  localparam int          DC_D_BIT      = 2;
  localparam int          DC_C_BIT      = 1;
  localparam int          DC_B_BIT      = 0;
  localparam int          EM_BIT        = 2;
  localparam int          EM_ID_BIT     = 1;
  localparam int          EM_S_BIT      = 0;
  localparam int          RH_BIT        = 1;
  localparam int          IM_BIT        = 1;

  typedef struct packed {
    logic       sel_data;
    logic       dir_read;
    logic [7:0] data;
  } clip_access_t;

  typedef struct packed {
    logic       bus_8bit;
    logic       two_line;
    logic       ext_set;
    logic       panel_on;
    logic       cursor_on;
    logic       blink_on;
    logic       addr_inc;
    logic       shift_on_write;
    logic       pictogram_only;
  } clip_mode_t;

  localparam clip_mode_t MODE_RESET = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
                                        1'b1, 1'b0, 1'b0};
endpackage

// ---- design/clip_text_ram.sv ----
`timescale 1ns/100ps
`default_nettype none
module clip_text_ram
  import clip_pkg::*;
(
  // clock
  input  wire logic              clk_in,
  // write port
  input  wire logic              wr_en_in,
  input  wire logic [6:0]        wr_addr_in,
  input  wire logic [7:0]        wr_data_in,
  // read port
  input  wire logic [6:0]        rd_addr_in,
  output logic [7:0]             rd_data_out
);
  logic [7:0] mem [0:TB_DEPTH-1];

  always_ff @(posedge clk_in)
  begin
    if (wr_en_in && wr_addr_in <= ADDR_LAST)
      mem[wr_addr_in] <= wr_data_in;
    rd_data_out <= (rd_addr_in <= ADDR_LAST) ? mem[rd_addr_in] : CHAR_BLANK;
  end
endmodule
`default_nettype wire

// ---- verification/clip_host.sv ----
`timescale 1ns/100ps
`default_nettype none
module clip_host
  import clip_pkg::*;
(
  // clock
  input  wire logic       clk_in,
  // parallel host bus
  output logic            strobe_out,
  output logic            sel_out,
  output logic            dir_out,
  output logic [7:0]      data_out
);
  logic four_bit;
  initial
  begin
    four_bit   = 1'b0;
    strobe_out = 1'b0;
    sel_out    = 1'b0;
    dir_out    = 1'b0;
    data_out   = 8'hff;
  end
  // pins settle 8 clk before the fall, 10 clk gap after
  task automatic pulse(input logic sel, input logic [7:0] d);
    @(posedge clk_in);
    #1 sel_out = sel;
    data_out = d;
    repeat (4) @(posedge clk_in);
    #1 strobe_out = 1'b1;
    repeat (4) @(posedge clk_in);
    #1 strobe_out = 1'b0;
    repeat (10) @(posedge clk_in);
    // released lines float up to the pull-ups
    #1 data_out = 8'hff;
  endtask
  // unconnected low lines read high
  task automatic put(input logic sel, input logic [7:0] b);
    if (four_bit)
    begin
      pulse(sel, {b[7:4], 4'hf});
      pulse(sel, {b[3:0], 4'hf});
    end
    else
      pulse(sel, b);
  endtask
  task automatic go_four();
    pulse(1'b0, 8'h2f);
    four_bit = 1'b1;
    put(1'b0, 8'h20);
  endtask
endmodule
`default_nettype wire

// ---- verification/char_lcd_instruction_port_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module char_lcd_instruction_port_tb_top;
  import clip_pkg::*;
  logic       clk_in;
  logic       rst_in;
  logic       sleep;
  logic [6:0] scan_addr;
  logic       strobe;
  logic       sel;
  logic       dir;
  logic [7:0] data;
  clip_mode_t mode;
  logic [6:0] cursor;
  logic [6:0] view;
  logic       active;
  logic       icon;
  logic       pdown;
  logic       pend;
  logic [7:0] scan_char;
  int         bad_count;
  int         checked;
  int         cycles;

  clip_host host (.clk_in(clk_in), .strobe_out(strobe), .sel_out(sel),
                  .dir_out(dir), .data_out(data));
  clip_core dut (.clk_in(clk_in), .rst_in(rst_in), .strobe_in(strobe),
                 .instruction_or_data_select_in(sel), .dir_read_in(dir),
                 .parallel_data_lines_in(data), .sleep_pin_in(sleep),
                 .mode_out(mode), .cursor_addr_out(cursor),
                 .view_offset_out(view), .display_active_out(active),
                 .icon_mode_out(icon), .power_down_out(pdown),
                 .nibble_pending_out(pend), .scan_addr_in(scan_addr),
                 .scan_char_out(scan_char));

  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  task automatic note(input logic ok, input string what);
    checked++;
    if (!ok)
    begin
      bad_count++;
      $display("Error at %0t: %s mismatch", $time, what);
    end
  endtask
  task automatic cmp_flag(input logic g, input logic e);
    note(g === e, "flag");
  endtask
  task automatic cmp_addr(input logic [6:0] g, input logic [6:0] e);
    note(g === e, "address");
  endtask
  task automatic cmp_char(input logic [6:0] a, input logic [7:0] e);
    @(posedge clk_in);
    #1 scan_addr = a;
    repeat (2) @(posedge clk_in);
    #1 note(scan_char === e, "character");
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      end_of_test();
    end
  end

  initial
  begin
    bad_count = 0;
    checked   = 0;
    cycles    = 0;
    rst_in    = 1'b1;
    sleep     = 1'b0;
    scan_addr = 7'h00;
    repeat (4) @(posedge clk_in);
    #1 rst_in = 1'b0;
    repeat (3) @(posedge clk_in);
    cmp_flag(mode.bus_8bit, 1'b1);
    cmp_addr(cursor, ADDR_RESET);
    done("reset");
    host.put(1'b0, 8'h30);
    cmp_flag(mode.bus_8bit, 1'b1);
    cmp_flag(mode.two_line, 1'b0);
    host.put(1'b0, 8'h0e);
    cmp_flag(mode.panel_on, 1'b1);
    cmp_flag(mode.cursor_on, 1'b1);
    cmp_flag(active, 1'b1);
    cmp_char(7'h05, CHAR_BLANK);
    host.put(1'b0, 8'h06);
    cmp_addr(cursor, 7'h00);
    cmp_char(7'h00, CHAR_BLANK);
    cmp_flag(mode.shift_on_write, 1'b0);
    host.put(1'b1, 8'h50);
    host.put(1'b1, 8'h48);
    cmp_addr(cursor, 7'h02);
    cmp_addr(view, 7'h00);
    cmp_char(7'h00, 8'h50);
    cmp_char(7'h01, 8'h48);
    done("write");
    host.put(1'b0, 8'h07);
    host.put(1'b1, 8'h53);
    cmp_addr(cursor, 7'h03);
    cmp_addr(view, 7'h01);
    host.put(1'b0, 8'h10);
    cmp_addr(cursor, 7'h02);
    cmp_addr(view, 7'h01);
    host.put(1'b0, 8'h14);
    cmp_addr(cursor, 7'h03);
    cmp_addr(view, 7'h01);
    host.put(1'b0, 8'h1c);
    cmp_addr(view, 7'h00);
    cmp_addr(cursor, 7'h03);
    host.put(1'b0, 8'h02);
    cmp_addr(cursor, 7'h00);
    cmp_addr(view, 7'h00);
    cmp_char(7'h00, 8'h50);
    cmp_char(7'h02, 8'h53);
    done("shift");
    host.put(1'b0, 8'h06);
    host.put(1'b0, 8'hcf);
    host.put(1'b1, 8'h41);
    cmp_addr(cursor, ADDR_RESET);
    cmp_char(ADDR_LAST, 8'h41);
    done("wrap");
    host.go_four();
    cmp_flag(mode.bus_8bit, 1'b0);
    host.pulse(1'b1, 8'h5f);
    cmp_flag(pend, 1'b1);
    host.pulse(1'b1, 8'h8f);
    cmp_flag(pend, 1'b0);
    cmp_addr(cursor, 7'h01);
    cmp_char(7'h00, 8'h58);
    done("nibble");
    host.put(1'b0, 8'h08);
    cmp_flag(mode.panel_on, 1'b0);
    cmp_flag(active, 1'b0);
    cmp_char(7'h00, 8'h58);
    host.put(1'b0, 8'h21);
    host.put(1'b0, 8'h0a);
    cmp_flag(mode.pictogram_only, 1'b1);
    cmp_flag(icon, 1'b1);
    host.put(1'b0, 8'h20);
    done("power");
    @(posedge clk_in);
    #1 sleep = 1'b1;
    repeat (10) @(posedge clk_in);
    cmp_flag(pdown, 1'b1);
    host.put(1'b1, 8'h33);
    cmp_addr(cursor, 7'h01);
    @(posedge clk_in);
    #1 sleep = 1'b0;
    repeat (10) @(posedge clk_in);
    cmp_flag(pdown, 1'b0);
    done("sleep");
    end_of_test();
  end
endmodule
`default_nettype wire
